// [core/psq_pkg.sv]
// shared constants and types of the power sequencer state control
package psq_pkg;
	localparam int NUM_CH = 12;
	localparam int CNT_W = 5;
	localparam logic [3:0] LAST_SLOT = 4'hf;
	localparam real CLK_MHZ = 200.0;
	localparam real BIST_TIME_MS = 12.5;
	localparam real STARTUP_MS = 50.0;
	localparam real FREQ_WIN_MS = 1.0;
	localparam real SLOT_TIME_US = 1.0;
	localparam real XTAL_KHZ = 32.768;
	localparam real TOL_PCT = 10.0;
	localparam int BIST_CYC = int'($floor(BIST_TIME_MS * 1000.0 * CLK_MHZ));
	localparam int STARTUP_CYC = int'($floor(STARTUP_MS * 1000.0 * CLK_MHZ));
	localparam int WIN_CYC = int'($floor(FREQ_WIN_MS * 1000.0 * CLK_MHZ));
	localparam int SLOT_CYC = int'($ceil(SLOT_TIME_US * CLK_MHZ));
	localparam real EDGES_NOM = XTAL_KHZ * FREQ_WIN_MS;
	localparam int EDGE_LO = int'($floor(EDGES_NOM * (100.0 - TOL_PCT) / 100.0));
	localparam int EDGE_HI = int'($ceil(EDGES_NOM * (100.0 + TOL_PCT) / 100.0));
	localparam int DATA_W = 8;
	localparam int CW_W = 13;
	localparam int CFG_WORDS = NUM_CH + 1;
	localparam logic [3:0] GLB_ADDR = 4'hc;
	localparam logic [7:0] GLB_RST_VAL = 8'h31;
	localparam logic [7:0] CH_RST_VAL = 8'h20;

	typedef enum logic [3:0] {
		ST_OFF, ST_SELFTEST, ST_LOAD, ST_SHDN_IDLE, ST_SEQ_UP, ST_ACTIVE,
		ST_SLEEP, ST_SEQ_DOWN, ST_EMERG, ST_BACKUP, ST_FAILSAFE
	} psq_state_t;

	typedef struct packed {
		logic [1:0] spare;
		logic en;
		logic sleep_grp;
		logic [3:0] slot;
	} psq_chan_cfg_t;

	typedef struct packed {
		logic [3:0] reset_release_delay;
		logic [1:0] spare;
		logic shdn_test;
		logic por_test;
	} psq_glb_cfg_t;

	typedef struct packed {
		logic valid;
		logic [3:0] addr;
		logic [7:0] data;
	} psq_cfg_wr_t;

	typedef struct packed {
		logic ded;
		logic sec;
		logic fail;
		logic ran;
	} psq_st_res_t;
endpackage : psq_pkg

// [core/psq_secded.sv]
// single-error-correct double-error-detect decoder for otp words
`timescale 1ns/100ps
`default_nettype none
module psq_secded (
	input wire logic [12:0] cw,
	output logic [7:0] data,
	output logic sec,
	output logic ded
);
	logic [3:0] syn;
	logic par;
	logic [12:0] fix;

	// bits 0..11 hold hamming positions 1..12, bit 12 the overall parity
	always_comb begin
		syn = 4'h0;
		par = ^cw;
		fix = cw;
		for (int p = 1; p <= 12; p++) begin
			if (cw[p - 1])
				syn = syn ^ 4'(p);
		end
		ded = ((syn != 4'h0) && !par) || (syn > 4'hc);
		sec = par && !ded;
		if (par && (syn != 4'h0) && (syn <= 4'hc))
			fix[syn - 4'h1] = !cw[syn - 4'h1];
		data = {fix[11:8], fix[6:4], fix[2]};
	end
endmodule : psq_secded
`default_nettype wire

// [core/psq_clk_mon.sv]
// slow clock frequency monitor over a fixed window of system cycles
`timescale 1ns/100ps
`default_nettype none
module psq_clk_mon #(
	parameter int WIN_CYCLES = psq_pkg::WIN_CYC,
	parameter int EDGE_LO = psq_pkg::EDGE_LO,
	parameter int EDGE_HI = psq_pkg::EDGE_HI
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic slow_edge,
	output logic fault
);
	logic [31:0] win_r, win_nxt;
	logic [7:0] edg_r, edg_nxt;
	logic [8:0] tot;
	logic win_end, fault_nxt;

	always_comb begin
		tot = {1'b0, edg_r} + {8'h00, slow_edge};
		win_end = enable && (win_r == 32'(WIN_CYCLES - 1));
		win_nxt = win_end ? 32'h0 : win_r + 32'h1;
		edg_nxt = win_end ? 8'h00 : (tot[8] ? 8'hff : tot[7:0]);
		fault_nxt = win_end && ((tot < 9'(EDGE_LO)) || (tot > 9'(EDGE_HI)));
		if (!enable) begin
			win_nxt = 32'h0;
			edg_nxt = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			win_r <= 32'h0;
			edg_r <= 8'h00;
			fault <= 1'b0;
		end else begin
			win_r <= win_nxt;
			edg_r <= edg_nxt;
			fault <= fault_nxt;
		end
	end

	AST_MON_AT_WINDOW_END: assert property (@(posedge sys_clk)
		disable iff (!resetn) fault |-> $past(win_end))
		else $error("frequency fault outside window end");
	AST_MON_IN_BOUNDS: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(win_end && tot >= 9'(EDGE_LO) && tot <= 9'(EDGE_HI)) |=> !fault)
		else $error("fault raised for in-tolerance count");
endmodule : psq_clk_mon
`default_nettype wire

// [core/psq_seq_ctrl.sv]
// state control of the multichannel power sequencer
// How it works
// - power-on self test only when its bit set
// - shutdown-exit test, skipped after software shutdown
// - otp configuration decoded through secded
// - self test: outputs low, inputs and i2c off
// - pass: i2c on, load, go shutdown idle
// - fail or double error: interrupt, fail-safe
// - self test outcome kept in result register
// - slow clock out and rtc from crystal
// - slow clock may start 50ms late
// - interrupt on slow clock off by 10%
// - supply loss: emergency down, backup or off
// - backup only after configuration was loaded
// - backup: rails, clock, reset low, inputs ignored
// - backup: rtc and status run, monitor off
// - backup entry keeps config, clears both keys
// - backup exit keeps config, goes shutdown idle
// - fail-safe: all outputs low, i2c kept
// - fail-safe left only by supply removal
// - channel config writable before active request
// - twelve sequenced output channels
// - reset released programmed delay after last slot (15)
// - emergency down: reset first, then rails low
`timescale 1ns/100ps
`default_nettype none
module psq_seq_ctrl #(
	parameter int NUM_CH = psq_pkg::NUM_CH,
	parameter int BIST_CYCLES = psq_pkg::BIST_CYC,
	parameter int STARTUP_CYCLES = psq_pkg::STARTUP_CYC,
	parameter int WIN_CYCLES = psq_pkg::WIN_CYC,
	parameter int SLOT_CYCLES = psq_pkg::SLOT_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic supply_ok,
	input wire logic battery_ok,
	input wire logic xtal_clk_in,
	input wire logic active_request_in,
	input wire logic sleep_request_n,
	input wire logic [1:0] software_shutdown_field,
	input wire logic selftest_fail_in,
	input wire logic [12:0] otp_word,
	output logic [3:0] otp_addr,
	input wire psq_pkg::psq_cfg_wr_t cfg_wr,
	input wire logic key_wr_en,
	input wire logic key_sel,
	input wire logic [7:0] key_data,
	input wire logic fault_clear,
	output logic [NUM_CH-1:0] rail_enable_outputs,
	output logic system_reset_out_n,
	output logic slow_clock_out,
	output logic interrupt_request_n,
	output logic i2c_active,
	output psq_pkg::psq_st_res_t selftest_result,
	output logic [31:0] rtc_time,
	output logic xtal_fault,
	output logic [7:0] protect_key_a,
	output logic [7:0] protect_key_b
);
	psq_pkg::psq_state_t st_r, st_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [3:0] ld_r, ld_nxt;
	logic step_r, step_nxt, ph_r, ph_nxt, swd_r, swd_nxt, slp_r, slp_nxt;
	logic tick, pd_req, powered, go_down;
	psq_pkg::psq_chan_cfg_t ch_r [NUM_CH];
	psq_pkg::psq_chan_cfg_t ch_nxt [NUM_CH];
	psq_pkg::psq_glb_cfg_t glb_r, glb_nxt;
	logic [7:0] ka_nxt, kb_nxt;
	logic loaded_r, loaded_nxt;
	psq_pkg::psq_st_res_t res_nxt;
	logic [NUM_CH-1:0] rail_want, rail_nxt;
	logic rst_n_nxt, clk_nxt, irq_n_nxt, i2c_nxt;
	logic xq_r, slow_edge, mon_en, mon_fault, fault_nxt;
	logic [31:0] rtc_nxt, su_r, su_nxt;
	logic su_done_r, su_done_nxt;
	logic [7:0] ecc_data;
	logic ecc_sec, ecc_ded;

	psq_secded u_ecc (
		.cw(otp_word),
		.data(ecc_data),
		.sec(ecc_sec),
		.ded(ecc_ded)
	);

	psq_clk_mon #(
		.WIN_CYCLES(WIN_CYCLES),
		.EDGE_LO(psq_pkg::EDGE_LO),
		.EDGE_HI(psq_pkg::EDGE_HI)
	) u_mon (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.enable(mon_en),
		.slow_edge(slow_edge),
		.fault(mon_fault)
	);

	// control state machine
	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		cnt_nxt = cnt_r;
		ld_nxt = ld_r;
		step_nxt = step_r;
		ph_nxt = ph_r;
		swd_nxt = swd_r;
		slp_nxt = slp_r;
		tick = (tmr_r == 32'(SLOT_CYCLES - 1));
		pd_req = !active_request_in || (software_shutdown_field != 2'b00);
		powered = !(st_r inside {psq_pkg::ST_OFF, psq_pkg::ST_BACKUP});
		go_down = 1'b0;
		if (powered && !supply_ok && st_r != psq_pkg::ST_EMERG) begin
			st_nxt = psq_pkg::ST_EMERG;
			step_nxt = 1'b0;
		end else begin
			unique case (st_r)
			psq_pkg::ST_OFF: begin
				tmr_nxt = 32'h0;
				ld_nxt = 4'h0;
				ph_nxt = 1'b0;
				if (supply_ok)
					st_nxt = glb_r.por_test ? psq_pkg::ST_SELFTEST :
						psq_pkg::ST_LOAD;
			end
			psq_pkg::ST_SELFTEST: begin
				tmr_nxt = tmr_r + 32'h1;
				if (tmr_r == 32'(BIST_CYCLES - 1)) begin
					tmr_nxt = 32'h0;
					ld_nxt = 4'h0;
					ph_nxt = 1'b0;
					st_nxt = selftest_fail_in ? psq_pkg::ST_FAILSAFE :
						psq_pkg::ST_LOAD;
				end
			end
			psq_pkg::ST_LOAD: begin
				ph_nxt = !ph_r;
				if (ph_r) begin
					if (ecc_ded)
						st_nxt = psq_pkg::ST_FAILSAFE;
					else if (ld_r == psq_pkg::GLB_ADDR)
						st_nxt = psq_pkg::ST_SHDN_IDLE;
					else
						ld_nxt = ld_r + 4'h1;
				end
			end
			psq_pkg::ST_SHDN_IDLE: begin
				tmr_nxt = 32'h0;
				cnt_nxt = 5'h00;
				slp_nxt = 1'b0;
				if (!pd_req)
					st_nxt = psq_pkg::ST_SEQ_UP;
			end
			psq_pkg::ST_SEQ_UP: begin
				tmr_nxt = tick ? 32'h0 : tmr_r + 32'h1;
				if (pd_req)
					go_down = 1'b1;
				else if (tick) begin
					if (cnt_r == 5'(psq_pkg::LAST_SLOT) + 5'(glb_r.reset_release_delay))
						st_nxt = psq_pkg::ST_ACTIVE;
					else
						cnt_nxt = cnt_r + 5'h01;
				end
			end
			psq_pkg::ST_ACTIVE: begin
				if (pd_req)
					go_down = 1'b1;
				else if (!sleep_request_n) begin
					st_nxt = psq_pkg::ST_SLEEP;
					slp_nxt = 1'b1;
				end
			end
			psq_pkg::ST_SLEEP: begin
				if (pd_req)
					go_down = 1'b1;
				else if (sleep_request_n) begin
					st_nxt = psq_pkg::ST_ACTIVE;
					slp_nxt = 1'b0;
				end
			end
			psq_pkg::ST_SEQ_DOWN: begin
				tmr_nxt = tick ? 32'h0 : tmr_r + 32'h1;
				if (tick) begin
					if (cnt_r == 5'h00) begin
						tmr_nxt = 32'h0;
						st_nxt = (glb_r.shdn_test && !swd_r) ?
							psq_pkg::ST_SELFTEST : psq_pkg::ST_SHDN_IDLE;
					end else
						cnt_nxt = cnt_r - 5'h01;
				end
			end
			psq_pkg::ST_EMERG: begin
				step_nxt = 1'b1;
				if (step_r)
					st_nxt = (battery_ok && loaded_r) ? psq_pkg::ST_BACKUP :
						psq_pkg::ST_OFF;
			end
			psq_pkg::ST_BACKUP: begin
				if (supply_ok)
					st_nxt = psq_pkg::ST_SHDN_IDLE;
				else if (!battery_ok)
					st_nxt = psq_pkg::ST_OFF;
			end
			psq_pkg::ST_FAILSAFE: begin
				st_nxt = psq_pkg::ST_FAILSAFE;
			end
			default: st_nxt = psq_pkg::ST_OFF;
			endcase
		end
		if (go_down) begin
			st_nxt = psq_pkg::ST_SEQ_DOWN;
			tmr_nxt = 32'h0;
			swd_nxt = (software_shutdown_field != 2'b00);
			if (cnt_r > 5'(psq_pkg::LAST_SLOT))
				cnt_nxt = 5'(psq_pkg::LAST_SLOT);
			if (st_r != psq_pkg::ST_SEQ_UP)
				cnt_nxt = 5'(psq_pkg::LAST_SLOT);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_r <= psq_pkg::ST_OFF;
			tmr_r <= 32'h0;
			cnt_r <= 5'h00;
			ld_r <= 4'h0;
			step_r <= 1'b0;
			ph_r <= 1'b0;
			swd_r <= 1'b0;
			slp_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			cnt_r <= cnt_nxt;
			ld_r <= ld_nxt;
			step_r <= step_nxt;
			ph_r <= ph_nxt;
			swd_r <= swd_nxt;
			slp_r <= slp_nxt;
		end
	end

	// configuration, keys and self test result
	always_comb begin
		ch_nxt = ch_r;
		glb_nxt = glb_r;
		ka_nxt = protect_key_a;
		kb_nxt = protect_key_b;
		loaded_nxt = loaded_r;
		res_nxt = selftest_result;
		if (st_r == psq_pkg::ST_LOAD && ph_r) begin
			res_nxt.sec = selftest_result.sec | ecc_sec;
			res_nxt.ded = selftest_result.ded | ecc_ded;
			if (!ecc_ded) begin
				if (ld_r == psq_pkg::GLB_ADDR)
					glb_nxt = psq_pkg::psq_glb_cfg_t'(ecc_data);
				else
					ch_nxt[ld_r] = psq_pkg::psq_chan_cfg_t'(ecc_data);
			end
		end
		// channel table writes only land while idle, before the active request
		if (cfg_wr.valid && st_r == psq_pkg::ST_SHDN_IDLE) begin
			if (cfg_wr.addr == psq_pkg::GLB_ADDR)
				glb_nxt = psq_pkg::psq_glb_cfg_t'(cfg_wr.data);
			else if (cfg_wr.addr < psq_pkg::GLB_ADDR)
				ch_nxt[cfg_wr.addr] = psq_pkg::psq_chan_cfg_t'(cfg_wr.data);
		end
		if (key_wr_en && i2c_active) begin
			if (key_sel)
				kb_nxt = key_data;
			else
				ka_nxt = key_data;
		end
		if (st_nxt == psq_pkg::ST_SELFTEST && st_r != psq_pkg::ST_SELFTEST)
			res_nxt = '0;
		if (st_r == psq_pkg::ST_SELFTEST && tmr_r == 32'(BIST_CYCLES - 1)) begin
			res_nxt.ran = 1'b1;
			res_nxt.fail = selftest_fail_in;
		end
		if (st_r == psq_pkg::ST_LOAD && st_nxt == psq_pkg::ST_SHDN_IDLE)
			loaded_nxt = 1'b1;
		if (st_nxt == psq_pkg::ST_OFF)
			loaded_nxt = 1'b0;
		if (st_nxt == psq_pkg::ST_BACKUP && st_r != psq_pkg::ST_BACKUP) begin
			ka_nxt = 8'h00;
			kb_nxt = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ch_r[i] <= psq_pkg::psq_chan_cfg_t'(psq_pkg::CH_RST_VAL | 8'(i + 1));
			end
			glb_r <= psq_pkg::psq_glb_cfg_t'(psq_pkg::GLB_RST_VAL);
			protect_key_a <= 8'h00;
			protect_key_b <= 8'h00;
			loaded_r <= 1'b0;
			selftest_result <= '0;
		end else begin
			ch_r <= ch_nxt;
			glb_r <= glb_nxt;
			protect_key_a <= ka_nxt;
			protect_key_b <= kb_nxt;
			loaded_r <= loaded_nxt;
			selftest_result <= res_nxt;
		end
	end

	// one rail per channel, on from its slot onward
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		assign rail_want[i] = ch_r[i].en && (ch_r[i].slot != 4'h0) &&
			(5'(ch_r[i].slot) <= cnt_r) && !(slp_r && ch_r[i].sleep_grp);
	end

	// pin levels per state
	always_comb begin
		rail_nxt = '0;
		rst_n_nxt = 1'b0;
		clk_nxt = 1'b0;
		irq_n_nxt = !(xtal_fault || selftest_result.fail || selftest_result.ded);
		i2c_nxt = 1'b1;
		unique case (st_r)
		psq_pkg::ST_OFF: begin
			irq_n_nxt = 1'b1;
			i2c_nxt = 1'b0;
		end
		psq_pkg::ST_SELFTEST: begin
			irq_n_nxt = !selftest_fail_in;
			i2c_nxt = 1'b0;
		end
		psq_pkg::ST_LOAD, psq_pkg::ST_SHDN_IDLE: begin
		end
		psq_pkg::ST_SEQ_UP, psq_pkg::ST_ACTIVE, psq_pkg::ST_SLEEP,
		psq_pkg::ST_SEQ_DOWN: begin
			rail_nxt = rail_want;
			rst_n_nxt = (st_r inside {psq_pkg::ST_ACTIVE, psq_pkg::ST_SLEEP});
			clk_nxt = xtal_clk_in;
		end
		psq_pkg::ST_EMERG: begin
			i2c_nxt = 1'b0;
			if (!step_r) begin
				rail_nxt = rail_enable_outputs;
				clk_nxt = slow_clock_out;
				irq_n_nxt = interrupt_request_n;
			end else
				irq_n_nxt = 1'b0;
		end
		psq_pkg::ST_BACKUP: begin
			i2c_nxt = 1'b0;
		end
		psq_pkg::ST_FAILSAFE: begin
			irq_n_nxt = 1'b0;
		end
		default: i2c_nxt = 1'b0;
		endcase
	end

	// crystal edge, rtc, startup wait and fault flag
	always_comb begin
		slow_edge = xtal_clk_in && !xq_r;
		rtc_nxt = (st_r == psq_pkg::ST_OFF) ? rtc_time :
			rtc_time + {31'h0, slow_edge};
		su_nxt = su_r;
		su_done_nxt = su_done_r;
		if (st_r == psq_pkg::ST_OFF) begin
			su_nxt = 32'h0;
			su_done_nxt = 1'b0;
		end else if (!su_done_r) begin
			su_nxt = su_r + 32'h1;
			su_done_nxt = (su_r == 32'(STARTUP_CYCLES - 1));
		end
		mon_en = su_done_r && (st_r inside {psq_pkg::ST_SHDN_IDLE,
			psq_pkg::ST_SEQ_UP, psq_pkg::ST_ACTIVE, psq_pkg::ST_SLEEP,
			psq_pkg::ST_SEQ_DOWN});
		// a fault in the clear cycle is kept
		fault_nxt = mon_fault || (xtal_fault && !fault_clear);
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			xq_r <= 1'b0;
			rtc_time <= 32'h0;
			su_r <= 32'h0;
			su_done_r <= 1'b0;
			xtal_fault <= 1'b0;
			rail_enable_outputs <= '0;
			system_reset_out_n <= 1'b0;
			slow_clock_out <= 1'b0;
			interrupt_request_n <= 1'b1;
			i2c_active <= 1'b0;
			otp_addr <= 4'h0;
		end else begin
			xq_r <= xtal_clk_in;
			rtc_time <= rtc_nxt;
			su_r <= su_nxt;
			su_done_r <= su_done_nxt;
			xtal_fault <= fault_nxt;
			rail_enable_outputs <= rail_nxt;
			system_reset_out_n <= rst_n_nxt;
			slow_clock_out <= clk_nxt;
			interrupt_request_n <= irq_n_nxt;
			i2c_active <= i2c_nxt;
			otp_addr <= ld_nxt;
		end
	end

	sequence s_emerg_step0;
		st_r == psq_pkg::ST_EMERG && !step_r;
	endsequence
	sequence s_emerg_step1;
		st_r == psq_pkg::ST_EMERG && step_r;
	endsequence

	AST_SELFTEST_PINS: assert property (@(posedge sys_clk)
		disable iff (!resetn) st_r == psq_pkg::ST_SELFTEST |=>
		(rail_enable_outputs == '0 && !system_reset_out_n && !slow_clock_out
		&& !i2c_active)) else $error("pins active during self test");
	AST_FAILSAFE_PINS: assert property (@(posedge sys_clk)
		disable iff (!resetn) st_r == psq_pkg::ST_FAILSAFE |=>
		(rail_enable_outputs == '0 && !system_reset_out_n && !slow_clock_out
		&& !interrupt_request_n && i2c_active))
		else $error("fail-safe pins wrong");
	AST_BACKUP_PINS: assert property (@(posedge sys_clk)
		disable iff (!resetn) st_r == psq_pkg::ST_BACKUP |=>
		(rail_enable_outputs == '0 && !system_reset_out_n && !slow_clock_out))
		else $error("backup pins wrong");
	AST_BACKUP_NEEDS_CFG: assert property (@(posedge sys_clk)
		disable iff (!resetn) $rose(st_r == psq_pkg::ST_BACKUP) |-> loaded_r)
		else $error("backup entered without configuration");
	AST_BACKUP_KEYS: assert property (@(posedge sys_clk)
		disable iff (!resetn) $rose(st_r == psq_pkg::ST_BACKUP) |->
		(protect_key_a == 8'h00 && protect_key_b == 8'h00))
		else $error("keys kept on backup entry");
	AST_EMERG_ORDER: assert property (@(posedge sys_clk)
		disable iff (!resetn) s_emerg_step0 ##1 s_emerg_step1 |->
		(!system_reset_out_n ##1 (rail_enable_outputs == '0 && !slow_clock_out)))
		else $error("emergency order broken");
	AST_SW_SHDN_NO_TEST: assert property (@(posedge sys_clk)
		disable iff (!resetn) (st_r == psq_pkg::ST_SEQ_DOWN && swd_r) ##1
		(st_r != psq_pkg::ST_SEQ_DOWN && supply_ok) |-> st_r != psq_pkg::ST_SELFTEST)
		else $error("self test after software shutdown");
	AST_POR_SKIP: assert property (@(posedge sys_clk)
		disable iff (!resetn) (st_r == psq_pkg::ST_OFF && supply_ok &&
		!glb_r.por_test) |=> st_r == psq_pkg::ST_LOAD)
		else $error("self test ran with bit clear");
	AST_RESET_RELEASE: assert property (@(posedge sys_clk)
		disable iff (!resetn) $rose(st_r == psq_pkg::ST_ACTIVE) &&
		$past(st_r) == psq_pkg::ST_SEQ_UP |->
		($past(cnt_r) == 5'(psq_pkg::LAST_SLOT) + 5'(glb_r.reset_release_delay))
		##1 system_reset_out_n) else $error("reset released off schedule");
	AST_FAULT_IRQ: assert property (@(posedge sys_clk)
		disable iff (!resetn) (mon_fault && supply_ok && st_r inside {
		psq_pkg::ST_SHDN_IDLE, psq_pkg::ST_SEQ_UP, psq_pkg::ST_ACTIVE,
		psq_pkg::ST_SLEEP}) |-> ##2 !interrupt_request_n)
		else $error("frequency fault did not interrupt");
endmodule : psq_seq_ctrl
`default_nettype wire

// [test/psq_otp_model.sv]
// otp memory model: configuration words with secded check bits
`timescale 1ns/100ps
`default_nettype none
module psq_otp_model (
	input wire logic sys_clk,
	input wire logic [3:0] otp_addr,
	input wire logic [3:0] sec_addr,
	input wire logic [3:0] ded_addr,
	output logic [12:0] otp_word
);
	logic [7:0] d;
	logic [11:0] h;
	logic [12:0] e;
	always_comb begin
		// global: delay 2, both test bits; word 11 disabled at slot 12
		if (otp_addr == 4'hc)
			d = 8'h23;
		else if (otp_addr == 4'hb)
			d = 8'h0c;
		else
			d = 8'h20 | 8'(otp_addr + 4'h1);
		h = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
		h[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
		h[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
		h[3] = d[1] ^ d[2] ^ d[3] ^ d[7];
		h[7] = d[4] ^ d[5] ^ d[6] ^ d[7];
		e = 13'h0;
		if (otp_addr == sec_addr)
			e = 13'h10;
		if (otp_addr == ded_addr)
			e = 13'h30;
	end
	// one cycle of read latency, within what the loader allows
	always_ff @(posedge sys_clk) begin
		otp_word <= {^h, h} ^ e;
	end
endmodule : psq_otp_model
`default_nettype wire

// [test/power_sequencer_state_control_test.sv]
// self-checking bench of the power sequencer state control
`timescale 1ns/100ps
`default_nettype none
module power_sequencer_state_control_test;
	typedef struct {int id; logic [31:0] v;} psq_note_t;
	logic sys_clk, resetn, supply_ok, active_request_in, fault_clear;
	logic battery_ok, sleep_request_n, key_sel;
	logic selftest_fail_in, key_wr_en, system_reset_out_n, slow_clock_out;
	logic interrupt_request_n, i2c_active, xtal_fault;
	logic xtal_clk_in = 1'b0;
	logic [1:0] software_shutdown_field;
	logic [3:0] otp_addr, sec_addr, ded_addr;
	logic [12:0] otp_word;
	logic [7:0] key_data, protect_key_a, protect_key_b, kd;
	logic [11:0] rail_enable_outputs;
	logic [31:0] rtc_time, t;
	psq_pkg::psq_cfg_wr_t cfg_wr;
	psq_pkg::psq_st_res_t selftest_result;
	int failures = 0;
	int total_checks = 0;
	int xhalf = 10;
	psq_note_t q[$];
	psq_note_t n;
	string nm[13] = '{"rails", "reset", "clk", "irq", "i2c", "ded",
		"xfault", "key_a", "rtc", "sec", "fail", "ran", "key_b"};

	psq_seq_ctrl #(.BIST_CYCLES(20), .STARTUP_CYCLES(10),
		.WIN_CYCLES(656), .SLOT_CYCLES(4)) uut (
		.sys_clk(sys_clk), .resetn(resetn), .supply_ok(supply_ok),
		.battery_ok(battery_ok), .xtal_clk_in(xtal_clk_in),
		.active_request_in(active_request_in),
		.sleep_request_n(sleep_request_n),
		.software_shutdown_field(software_shutdown_field),
		.selftest_fail_in(selftest_fail_in), .otp_word(otp_word),
		.otp_addr(otp_addr), .cfg_wr(cfg_wr), .key_wr_en(key_wr_en),
		.key_sel(key_sel), .key_data(key_data), .fault_clear(fault_clear),
		.rail_enable_outputs(rail_enable_outputs),
		.system_reset_out_n(system_reset_out_n),
		.slow_clock_out(slow_clock_out),
		.interrupt_request_n(interrupt_request_n),
		.i2c_active(i2c_active), .selftest_result(selftest_result),
		.rtc_time(rtc_time), .xtal_fault(xtal_fault),
		.protect_key_a(protect_key_a), .protect_key_b(protect_key_b));
	psq_otp_model otp (.sys_clk(sys_clk), .otp_addr(otp_addr),
		.sec_addr(sec_addr), .ded_addr(ded_addr), .otp_word(otp_word));

	function automatic logic [31:0] obs(int id);
		case (id)
			0: return 32'(rail_enable_outputs);
			1: return 32'(system_reset_out_n);
			2: return 32'(slow_clock_out);
			3: return 32'(interrupt_request_n);
			4: return 32'(i2c_active);
			5: return 32'(selftest_result.ded);
			6: return 32'(xtal_fault);
			7: return 32'(protect_key_a);
			8: return rtc_time;
			9: return 32'(selftest_result.sec);
			10: return 32'(selftest_result.fail);
			11: return 32'(selftest_result.ran);
			default: return 32'(protect_key_b);
		endcase
	endfunction : obs

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task automatic note(int id, logic [31:0] v);
		q.push_back('{id, v});
	endtask : note

	task automatic cyc(int k);
		repeat (k) @(negedge sys_clk);
	endtask : cyc

	// bounded wait, then the value is noted whether it came or not
	task automatic wait_for(int id, logic [31:0] v, int max);
		int k;
		k = 0;
		while (obs(id) !== v && k < max) begin
			@(negedge sys_clk);
			k++;
		end
		note(id, v);
	endtask : wait_for

	task automatic wr(logic [3:0] a, logic [7:0] d);
		cfg_wr = '{valid: 1'b1, addr: a, data: d};
		cyc(1);
		cfg_wr.valid = 1'b0;
		cyc(1);
	endtask : wr

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial forever begin
		repeat (xhalf) @(negedge sys_clk);
		xtal_clk_in = ~xtal_clk_in;
	end

	initial forever begin
		@(negedge sys_clk);
		#1;
		while (q.size() > 0) begin
			n = q.pop_front();
			check(nm[n.id], obs(n.id), n.v);
		end
	end

	initial begin
		#200000;
		failures++;
		give_verdict();
	end

	initial begin
		resetn = 1'b0;
		{supply_ok, active_request_in, fault_clear, selftest_fail_in} = 4'h0;
		{key_wr_en, key_data, software_shutdown_field} = 11'h0;
		{battery_ok, sleep_request_n, key_sel} = 3'h6;
		cfg_wr = '0;
		sec_addr = 4'h3;
		ded_addr = 4'h5;
		void'($urandom(32'h5c4c));
		cyc(8);
		resetn = 1'b1;
		supply_ok = 1'b1;
		wait_for(3, 0, 200);
		note(5, 1);
		active_request_in = 1'b1;
		cyc(20);
		note(0, 0);
		note(1, 0);
		active_request_in = 1'b0;
		supply_ok = 1'b0;
		cyc(5);
		t = rtc_time;
		cyc(60);
		note(8, t);
		ded_addr = 4'hf;
		selftest_fail_in = 1'b1;
		supply_ok = 1'b1;
		wait_for(10, 1, 200);
		note(11, 1);
		note(3, 0);
		supply_ok = 1'b0;
		selftest_fail_in = 1'b0;
		cyc(10);
		supply_ok = 1'b1;
		cyc(10);
		note(0, 0);
		note(1, 0);
		note(2, 0);
		note(3, 1);
		note(4, 0);
		wait_for(4, 1, 100);
		// i2c comes up at load start; table writes need idle
		cyc(30);
		note(9, 1);
		note(11, 1);
		kd = 8'($urandom);
		key_data = kd;
		key_wr_en = 1'b1;
		cyc(1);
		key_sel = 1'b1;
		key_data = ~kd;
		cyc(1);
		key_wr_en = 1'b0;
		note(7, 32'(kd));
		note(12, {24'h0, ~kd});
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h32);
		wr(4'hd, 8'hff);
		active_request_in = 1'b1;
		wait_for(1, 1, 200);
		note(0, 12'h7fe);
		wait_for(2, 1, 50);
		sleep_request_n = 1'b0;
		cyc(3);
		note(0, 12'h7fc);
		sleep_request_n = 1'b1;
		cyc(3);
		note(0, 12'h7fe);
		software_shutdown_field = 2'b01;
		wait_for(1, 0, 4);
		wait_for(0, 0, 200);
		cyc(14);
		note(4, 1);
		software_shutdown_field = 2'b00;
		wait_for(1, 1, 200);
		active_request_in = 1'b0;
		wait_for(4, 0, 200);
		wait_for(4, 1, 200);
		xhalf = 8;
		wait_for(6, 1, 3000);
		cyc(2);
		note(3, 0);
		xhalf = 10;
		cyc(1400);
		fault_clear = 1'b1;
		cyc(1);
		fault_clear = 1'b0;
		cyc(3);
		note(6, 0);
		note(3, 1);
		active_request_in = 1'b1;
		wait_for(1, 1, 200);
		supply_ok = 1'b0;
		wait_for(1, 0, 4);
		note(0, 12'h7ff);
		cyc(4);
		note(0, 0);
		note(2, 0);
		note(1, 0);
		note(7, 0);
		note(12, 0);
		t = rtc_time;
		cyc(60);
		note(8, t + 32'h3);
		active_request_in = 1'b0;
		supply_ok = 1'b1;
		wait_for(4, 1, 10);
		note(1, 0);
		wr(4'hc, 8'h22);
		battery_ok = 1'b0;
		supply_ok = 1'b0;
		cyc(5);
		t = rtc_time;
		cyc(60);
		note(8, t);
		supply_ok = 1'b1;
		wait_for(4, 1, 4);
		cyc(2);
		give_verdict();
	end
endmodule : power_sequencer_state_control_test
`default_nettype wire
